/* File: acr_pkg.sv */
// Constants shared by the result readout block of the 16-bit converter.
// Assumes a single 25 MHz system clock and a converter core on the same clock.
package acr_pkg;
   // -----------------------------------------------------------------
   // Result and timing
   // -----------------------------------------------------------------
   localparam int          RESULT_BITS   = 16;
   localparam int          CNT_W         = 5;
   localparam logic [4:0]  BITS_FULL     = 5'h10;
   localparam int          CLK_PERIOD_NS = 40;
   localparam int          CONV_TIME_NS  = 10000;
   localparam int          CONV_CYCLES   = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [7:0]  CONV_LAST     = 8'(CONV_CYCLES - 1);
   // -----------------------------------------------------------------
   // Reset values
   // -----------------------------------------------------------------
   localparam logic [15:0] RESULT_RST    = 16'h0000;
   // Select, read and convert start idle high, so no false edge after reset
   localparam logic [13:0] PINS_RST      = 14'h0007;
   // -----------------------------------------------------------------
   // Synchronised pin vector positions
   // -----------------------------------------------------------------
   localparam int P_CNV  = 0;
   localparam int P_CS   = 1;
   localparam int P_RD   = 2;
   localparam int P_SCLK = 3;
   localparam int P_CHN  = 4;
   localparam int P_SWAP = 5;
   localparam int P_SER  = 6;
   localparam int P_SRC  = 7;
   localparam int P_DIV0 = 8;
   localparam int P_DIV1 = 9;
   localparam int P_CINV = 10;
   localparam int P_SINV = 11;
   localparam int P_IDLH = 12;
   localparam int P_SPR  = 13;
   // -----------------------------------------------------------------
   // Master sequencer states
   // -----------------------------------------------------------------
   typedef enum logic [0:0] {
      ACR_M_IDLE = 1'b0,
      ACR_M_SEND = 1'b1
   } acr_mstate_t;
   // Half period of the master serial clock in system cycles, minus one
   function automatic logic [2:0] acr_half_last(input logic [1:0] sel);
      case (sel)
         2'b00:   acr_half_last = 3'h0;
         2'b01:   acr_half_last = 3'h1;
         2'b10:   acr_half_last = 3'h3;
         default: acr_half_last = 3'h7;
      endcase
   endfunction : acr_half_last
endpackage : acr_pkg

/* File: acr_readout.sv */
// Result readout of a 16-bit successive-approximation converter: parallel
// output with half swap, master and slave serial output, daisy chain.
// Assumes the core's result on conv_result is settled in the last cycle of
// the timed conversion, where it is taken. All pins are asynchronous and
// pass two flip-flops, which limits how fast a host clock may toggle.
// How it works
// - Swap low: low byte on low lines
// - Swap high: bytes exchanged on the bus
// - Serial mode: 16 bits, MSB first
// - Master: own serial clock and frame strobe
// - Master clock and strobe may be inverted
// - Master bit held stable across whole period
// - Timing input picks after or during conversion
// - Master read-after: busy until 16 bits sent
// - Divider select slows the master clock
// - Both divider selects low: fastest clock
// - Slave: serial clock taken from host
// - Clock gated by select, data by select/read
// - Slave clock continuous or gated, any idle
// - Slave after busy falls: new result out
// - Slave clock rate limited to a sixth of the 25 MHz system clock
// - Slave read-after: timing input chains converters
// - Chain captured on opposite edge to shift
// - Slave during conversion: previous result out
// - Unfinished read during conversion pulses error
// - Outputs released while select or read high
// - Convert start falling edge begins conversion
`timescale 1ns/1ps
`default_nettype none
module acr_readout
   import acr_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   input  wire logic        convert_start_n,
   input  wire logic        chip_select_n,
   input  wire logic        read_n,
   input  wire logic        serial_clock_in,
   input  wire logic        read_timing_or_chain_input,
   input  wire logic        half_swap_select,
   input  wire logic        serial_parallel_select,
   input  wire logic        clock_source_select,
   input  wire logic [1:0]  serial_clock_divider_select,
   input  wire logic        serial_clock_invert,
   input  wire logic        frame_strobe_invert,
   input  wire logic        slave_clock_idle_high,
   input  wire logic [15:0] conv_result,
   output logic             conv_start,
   output logic             busy,
   output logic [15:0]      data_out,
   output logic             data_oe,
   output logic             serial_result_out,
   output logic             serial_result_oe,
   output logic             serial_clock_out,
   output logic             serial_clock_oe,
   output logic             frame_strobe_out,
   output logic             frame_strobe_oe,
   output logic             incomplete_read_flag
);
   // -----------------------------------------------------------------
   // Pin synchronisers
   // -----------------------------------------------------------------
   logic [13:0] pin_meta_r;
   logic [13:0] pin_r;
   logic [13:0] pin_raw;
   assign pin_raw = {1'b0, slave_clock_idle_high, frame_strobe_invert, serial_clock_invert,
                     serial_clock_divider_select, clock_source_select, serial_parallel_select,
                     half_swap_select, read_timing_or_chain_input, serial_clock_in,
                     read_n, chip_select_n, convert_start_n};
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pin_meta_r <= PINS_RST;
         pin_r      <= PINS_RST;
      end else begin
         pin_meta_r <= pin_raw;
         pin_r      <= pin_meta_r;
      end
   end

   logic cnv_d_r;
   logic sclk_d_r;
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cnv_d_r  <= 1'b1;
         sclk_d_r <= 1'b0;
      end else begin
         cnv_d_r  <= pin_r[P_CNV];
         sclk_d_r <= pin_r[P_SCLK];
      end
   end

   logic master;
   logic rdc;
   logic if_en;
   assign master = ~pin_r[P_SRC];
   assign rdc    = pin_r[P_CHN];
   assign if_en  = ~pin_r[P_CS] & ~pin_r[P_RD];
   // -----------------------------------------------------------------
   // Conversion timing
   // -----------------------------------------------------------------
   logic       conv_busy_r;
   logic [7:0] conv_cnt_r;
   logic       start_evt;
   logic       conv_end;
   logic [15:0] result_r;
   // A running conversion cannot be restarted, so edges while busy are dropped
   assign start_evt  = cnv_d_r & ~pin_r[P_CNV] & ~conv_busy_r;
   assign conv_end   = conv_busy_r & (conv_cnt_r == 8'h00);
   assign conv_start = start_evt;
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         conv_busy_r <= 1'b0;
         conv_cnt_r  <= 8'h00;
      end else if (start_evt) begin
         conv_busy_r <= 1'b1;
         conv_cnt_r  <= CONV_LAST;
      end else if (conv_end) begin
         conv_busy_r <= 1'b0;
      end else if (conv_busy_r) begin
         conv_cnt_r  <= conv_cnt_r - 8'h01;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         result_r <= RESULT_RST;
      end else if (conv_end) begin
         result_r <= conv_result;
      end
   end
   // -----------------------------------------------------------------
   // Master clock divider and sequencer
   // -----------------------------------------------------------------
   acr_mstate_t m_state_r;
   logic [2:0]  div_cnt_r;
   logic        m_tick;
   logic        m_sclk_r;
   logic        send_go;
   logic        m_fall;
   logic        m_done;
   logic [4:0]  cnt_r;
   assign m_tick  = (div_cnt_r == 3'h0);
   assign send_go = master & pin_r[P_SER] & (rdc ? start_evt : conv_end);
   assign m_fall  = (m_state_r == ACR_M_SEND) & m_tick & m_sclk_r;
   assign m_done  = m_fall & (cnt_r == BITS_FULL - 5'h01);

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         div_cnt_r <= 3'h0;
      end else if (send_go || m_tick) begin
         div_cnt_r <= acr_half_last(pin_r[P_DIV1:P_DIV0]);
      end else begin
         div_cnt_r <= div_cnt_r - 3'h1;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         m_state_r <= ACR_M_IDLE;
         m_sclk_r  <= 1'b0;
      end else begin
         case (m_state_r)
            ACR_M_IDLE: begin
               m_sclk_r <= 1'b0;
               if (send_go) begin
                  m_state_r <= ACR_M_SEND;
               end
            end
            ACR_M_SEND: begin
               if (m_tick) begin
                  m_sclk_r <= ~m_sclk_r;
               end
               if (m_done) begin
                  m_state_r <= ACR_M_IDLE;
               end
            end
            default: begin
               m_state_r <= ACR_M_IDLE;
               m_sclk_r  <= 1'b0;
            end
         endcase
      end
   end
   // -----------------------------------------------------------------
   // Slave clock edges
   // -----------------------------------------------------------------
   logic s_rise;
   logic s_fall;
   logic s_shift;
   logic s_cap;
   logic slave_on;
   assign slave_on = ~master & pin_r[P_SER] & ~pin_r[P_CS];
   assign s_rise   = pin_r[P_SCLK] & ~sclk_d_r;
   assign s_fall   = ~pin_r[P_SCLK] & sclk_d_r;
   // Shift on the edge that ends a pulse, so idle level picks the edge
   assign s_shift  = slave_on & ~pin_r[P_RD] &
                     (pin_r[P_IDLH] ? s_rise : s_fall);
   assign s_cap    = slave_on & (pin_r[P_IDLH] ? s_fall : s_rise);
   // -----------------------------------------------------------------
   // Output shift register
   // -----------------------------------------------------------------
   logic [15:0] sr_r;
   logic        chain_bit_r;
   logic        sr_load;
   logic [15:0] sr_load_val;
   logic        shift_en;
   assign sr_load     = master ? send_go : (start_evt | conv_end);
   // In master read-after the new result is not yet in result_r
   assign sr_load_val = (start_evt || (master && rdc)) ? result_r : conv_result;
   assign shift_en    = m_fall | s_shift;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         chain_bit_r <= 1'b0;
      end else if (s_cap) begin
         chain_bit_r <= rdc;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sr_r  <= RESULT_RST;
         cnt_r <= 5'h00;
      end else if (sr_load) begin
         sr_r  <= sr_load_val;
         cnt_r <= 5'h00;
      end else if (shift_en) begin
         sr_r  <= {sr_r[14:0], chain_bit_r & ~master};
         cnt_r <= (cnt_r == BITS_FULL) ? cnt_r : cnt_r + 5'h01;
      end
   end
   // -----------------------------------------------------------------
   // Incomplete read detection
   // -----------------------------------------------------------------
   logic rd_during_r;
   logic err_r;
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rd_during_r <= 1'b0;
      end else if (start_evt) begin
         rd_during_r <= 1'b0;
      end else if (s_shift && conv_busy_r) begin
         rd_during_r <= 1'b1;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         err_r <= 1'b0;
      end else begin
         err_r <= conv_end & ~master & rd_during_r & (cnt_r != BITS_FULL);
      end
   end
   // -----------------------------------------------------------------
   // Parallel data and outputs
   // -----------------------------------------------------------------
   logic [15:0] par_r;
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         par_r <= RESULT_RST;
      end else if (pin_r[P_SWAP]) begin
         par_r <= {result_r[7:0], result_r[15:8]};
      end else begin
         par_r <= result_r;
      end
   end

   assign data_out             = par_r;
   assign data_oe              = if_en & ~pin_r[P_SER];
   assign serial_result_out    = sr_r[15];
   assign serial_result_oe     = if_en & pin_r[P_SER];
   assign serial_clock_out     = m_sclk_r ^ pin_r[P_CINV];
   assign serial_clock_oe      = if_en & pin_r[P_SER] & master;
   assign frame_strobe_out     = (m_state_r == ACR_M_SEND) ^ pin_r[P_SINV];
   assign frame_strobe_oe      = if_en & pin_r[P_SER] & master;
   assign busy                 = conv_busy_r | ((m_state_r == ACR_M_SEND) & ~rdc);
   assign incomplete_read_flag = err_r;
   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   sequence s_start;
      start_evt;
   endsequence
   sequence s_conv_hold;
      conv_busy_r [*8];
   endsequence
   AST_SWAP_LOW: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !pin_r[P_SWAP] |=> par_r == $past(result_r))
      else $error("unswapped bytes wrong");
   AST_SWAP_HIGH: assert property (@(posedge clk_sys) disable iff (!rst_n)
      pin_r[P_SWAP] |=> par_r == {$past(result_r[7:0]), $past(result_r[15:8])})
      else $error("swapped bytes wrong");
   AST_CONV_START: assert property (@(posedge clk_sys) disable iff (!rst_n)
      s_start |=> s_conv_hold)
      else $error("busy not held after start");
   AST_BUSY_SEND: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (m_state_r == ACR_M_SEND) && !rdc |-> busy)
      else $error("busy dropped while sending");
   AST_FAST_CLK: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (m_state_r == ACR_M_SEND) && pin_r[P_DIV1:P_DIV0] == 2'b00 && $stable(pin_r)
      && $past(m_state_r) == ACR_M_SEND |-> m_sclk_r != $past(m_sclk_r))
      else $error("master clock not at full rate");
   AST_GATED: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (pin_r[P_CS] || pin_r[P_RD]) && !sr_load |=> cnt_r == $past(cnt_r) || master)
      else $error("slave pointer moved while deselected");
   AST_RELEASE: assert property (@(posedge clk_sys) disable iff (!rst_n)
      pin_r[P_CS] || pin_r[P_RD] |-> !data_oe && !serial_result_oe && !serial_clock_oe)
      else $error("output driven while deselected");
   AST_ERR_PULSE: assert property (@(posedge clk_sys) disable iff (!rst_n)
      err_r |=> !err_r)
      else $error("error flag not a pulse");
   AST_SEND_LEN: assert property (@(posedge clk_sys) disable iff (!rst_n)
      m_done && !sr_load |=> m_state_r == ACR_M_IDLE && cnt_r == BITS_FULL)
      else $error("master sent wrong bit count");
endmodule : acr_readout
`default_nettype wire

/* File: acr_host_model.sv */
// Host side of the readout: a slave serial reader with a gated clock.
// Assumes the bench supplies clk_sys and calls read() or sets the selects.
`timescale 1ns/1ps
`default_nettype none
module acr_host_model (
   input  wire logic clk_sys,
   input  wire logic sdo,
   input  wire logic sdo_oe,
   output logic      sclk,
   output logic      cs_n,
   output logic      rd_n
);
   logic [31:0] word;
   logic        last = 1'h0;
   // A released line shows the inverse of its last value, never a stale copy
   wire  logic  line = sdo_oe ? sdo : ~last;
   always @(posedge clk_sys) begin
      if (sdo_oe) begin
         last <= sdo;
      end
   end
   initial begin
      sclk = 1'h0;
      cs_n = 1'h1;
      rd_n = 1'h1;
      word = 32'h0;
   end
   // -----------------------------------------------------------------
   // Read burst
   // -----------------------------------------------------------------
   // Clock idles at the chosen level and toggles only inside a burst
   // Half period of three cycles or more keeps under the limit
   // Idle level settles while deselected, so its change is never an edge
   task automatic read(input int n, input int half, input logic idle);
      if (sclk !== idle) begin
         sclk = idle;
         repeat (3) @(negedge clk_sys);
      end
      cs_n = 1'h0;
      rd_n = 1'h0;
      repeat (3) @(negedge clk_sys);
      for (int i = 0; i < n; i++) begin
         word = {word[30:0], line};
         sclk = ~idle;
         repeat (half) @(negedge clk_sys);
         sclk = idle;
         repeat (half) @(negedge clk_sys);
      end
      cs_n = 1'h1;
      rd_n = 1'h1;
      repeat (2) @(negedge clk_sys);
   endtask : read
   // Both selects held for parallel and master transfers
   task automatic hold_select(input logic on);
      cs_n = ~on;
      rd_n = ~on;
   endtask : hold_select
endmodule : acr_host_model
`default_nettype wire

/* File: tb_adc_result_readout_interface.sv */
// Self-checking bench of the readout: parallel, master and slave serial.
// Assumes the host model owns the slave clock and both select lines.
`timescale 1ns/1ps
`default_nettype none
module tb_adc_result_readout_interface;
   import acr_pkg::*;
   logic        clk_sys, rst_n, convert_start_n, rdc, swap, ser, src, sinv, finv, sc_q, idlh;
   logic [1:0]  div;
   logic [15:0] conv_result, mbits;
   logic [31:0] rnd;
   logic [15:0] hist[$];
   int          miscompares, check_count, starts, errs, fs_cnt;
   wire  logic  sclk, cs_n, rd_n, conv_start, busy, data_oe, sdo, sdo_oe;
   wire  logic  sclk_o, sclk_oe, fs_o, fs_oe, rderr;
   wire  logic [15:0] data_out;
   acr_readout acr_readout_inst (.clk_sys(clk_sys), .rst_n(rst_n),
      .convert_start_n(convert_start_n), .chip_select_n(cs_n), .read_n(rd_n),
      .serial_clock_in(sclk), .read_timing_or_chain_input(rdc), .half_swap_select(swap),
      .serial_parallel_select(ser), .clock_source_select(src),
      .serial_clock_divider_select(div), .serial_clock_invert(sinv),
      .frame_strobe_invert(finv), .slave_clock_idle_high(idlh), .conv_result(conv_result),
      .conv_start(conv_start), .busy(busy), .data_out(data_out), .data_oe(data_oe),
      .serial_result_out(sdo), .serial_result_oe(sdo_oe), .serial_clock_out(sclk_o),
      .serial_clock_oe(sclk_oe), .frame_strobe_out(fs_o), .frame_strobe_oe(fs_oe),
      .incomplete_read_flag(rderr));
   acr_host_model acr_host_model_inst (.clk_sys(clk_sys), .sdo(sdo), .sdo_oe(sdo_oe),
      .sclk(sclk), .cs_n(cs_n), .rd_n(rd_n));
   initial begin
      clk_sys = 1'h0;
      forever #20 clk_sys = ~clk_sys;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   task automatic conclude();
      if (miscompares == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : conclude
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic wait_busy(input logic lvl, input int lim);
      int n;
      n = 0;
      while (busy !== lvl && n < lim) begin
         @(negedge clk_sys);
         n++;
      end
      if (busy !== lvl) begin
         chk("busy_wait", busy, lvl);
         conclude();
      end
   endtask : wait_busy
   // -----------------------------------------------------------------
   // Conversion with an optional refused restart
   // -----------------------------------------------------------------
   task automatic conv(input logic refuse);
      rnd = lfsr(rnd);
      conv_result = rnd[15:0];
      hist.push_back(rnd[15:0]);
      starts = 0;
      errs = 0;
      fs_cnt = 0;
      mbits = 16'h0;
      convert_start_n = 1'h0;
      wait_busy(1'h1, 10);
      convert_start_n = 1'h1;
      if (refuse) begin
         repeat (4) @(negedge clk_sys);
         convert_start_n = 1'h0;
         repeat (4) @(negedge clk_sys);
         convert_start_n = 1'h1;
      end
   endtask : conv
   // Master bits taken in the first high cycle of the nominal clock, once settled
   always @(negedge clk_sys) begin
      if (conv_start === 1'h1) starts++;
      if (rderr === 1'h1) errs++;
      sc_q <= sclk_o ^ sinv;
      if ((fs_o ^ finv) === 1'h1) begin
         fs_cnt++;
         if ((sclk_o ^ sinv) === 1'h1 && sc_q === 1'h0) mbits = {mbits[14:0], sdo};
      end
   end
   // -----------------------------------------------------------------
   // Main sequence
   // -----------------------------------------------------------------
   initial begin
      rst_n = 1'h0;
      convert_start_n = 1'h1;
      rdc = 1'h0;
      swap = 1'h0;
      ser = 1'h0;
      src = 1'h1;
      sinv = 1'h0;
      finv = 1'h0;
      idlh = 1'h0;
      div = 2'h0;
      conv_result = 16'h0;
      rnd = 32'h8262CDF1;
      repeat (3) @(negedge clk_sys);
      rst_n = 1'h1;
      repeat (4) @(negedge clk_sys);
      acr_host_model_inst.hold_select(1'h1);
      for (int s = 0; s < 2; s++) begin
         swap = s[0];
         conv(1'h1);
         wait_busy(1'h0, 400);
         chk("starts", starts, 1);
         repeat (3) @(negedge clk_sys);
         chk("par", data_out, swap ? {hist[$][7:0], hist[$][15:8]} : hist[$]);
         chk("data_oe", data_oe, 1);
      end
      ser = 1'h1;
      src = 1'h0;
      for (int d = 0; d < 5; d++) begin
         div = d[1:0];
         sinv = d[0];
         finv = d[1];
         rdc = d[2];
         repeat (4) @(negedge clk_sys);
         conv(1'h0);
         chk("sclk_oe", sclk_oe & fs_oe, 1);
         wait_busy(1'h0, 600);
         chk("master_bits", mbits, d[2] ? hist[$-1] : hist[$]);
         chk("strobe_len", fs_cnt, 32 << d[1:0]);
      end
      src = 1'h1;
      acr_host_model_inst.hold_select(1'h0);
      for (int c = 0; c < 2; c++) begin
         rdc = c[0];
         idlh = c[0];
         conv(1'h1);
         wait_busy(1'h0, 400);
         acr_host_model_inst.word = 32'h0;
         acr_host_model_inst.read(18, 6, idlh);
         chk("slave", acr_host_model_inst.word[17:0], {hist[$], c[0], c[0]});
         repeat (2) @(negedge clk_sys);
         chk("sdo_oe", sdo_oe, 0);
      end
      rdc = 1'h0; // Held fixed while reading during conversion
      idlh = 1'h0;
      // Both halves end inside the first half of busy
      conv(1'h0);
      acr_host_model_inst.word = 32'h0;
      acr_host_model_inst.read(8, 3, 1'h0);
      acr_host_model_inst.read(8, 3, 1'h0);
      wait_busy(1'h0, 400);
      repeat (3) @(negedge clk_sys);
      chk("during_word", acr_host_model_inst.word[15:0], hist[$-1]);
      chk("err_none", errs, 0);
      conv(1'h0);
      acr_host_model_inst.read(8, 3, 1'h0);
      wait_busy(1'h0, 400);
      repeat (3) @(negedge clk_sys);
      chk("err_pulse", errs, 1);
      conclude();
   end
endmodule : tb_adc_result_readout_interface
`default_nettype wire
